// *** core/print_if_pkg.sv ***
// Constants, field layout and carrier types for the print controller host interface
package print_if_pkg;

	// Clock and timing
	localparam int CLK_HZ = 20_000_000;
	localparam int NORM_PARK_MS = 20;
	localparam int NORM_PARK_CYC = NORM_PARK_MS * (CLK_HZ / 1000);
	localparam int FAST_PARK_US = 32;
	localparam int FAST_PARK_CYC = FAST_PARK_US * (CLK_HZ / 1_000_000);
	localparam int INIT_MS = 500;
	localparam int INIT_CYC = INIT_MS * (CLK_HZ / 1000);
	localparam int BOOT_US = 100;
	localparam int BOOT_CYC = BOOT_US * (CLK_HZ / 1_000_000);
	localparam int VSYNC_LOSS_MS = 50;
	localparam int VSYNC_LOSS_CYC = VSYNC_LOSS_MS * (CLK_HZ / 1000);
	localparam int PRINT_SETUP_US = 1000;
	localparam int PRINT_SETUP_CYC = PRINT_SETUP_US * (CLK_HZ / 1_000_000);
	localparam int SYNC_LAT = 3;
	localparam int CNT_W = 24;

	// Frame geometry
	localparam int PIX_W = 8;
	localparam int POS_W = 11;
	localparam logic [POS_W-1:0] LAND_COLS = 11'h500;
	localparam logic [POS_W-1:0] LAND_ROWS = 11'h2d0;
	localparam logic [POS_W-1:0] PORT_COLS = 11'h2d0;

	// Register bus
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_LAYER = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_CMD = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_BRIGHT = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_FRAMES = 8'h14;

	// Control field positions
	localparam int CTRL_PRINT = 0;
	localparam int CTRL_ROTATE = 1;
	localparam int CTRL_MASK_LOW = 2;
	localparam int CTRL_VS_FALL = 3;
	localparam int CTRL_HS_FALL = 4;
	localparam int CTRL_W = 5;
	localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
	localparam int CMD_LAYER = 0;
	localparam int LAYER_W = 16;
	localparam logic [LAYER_W-1:0] LAYER_RST = 16'h0001;
	localparam logic [PIX_W-1:0] BRIGHT_RST = 8'h00;
	localparam int FRAMES_W = 16;

	// Async pins grouped for the synchroniser chain
	typedef struct packed {
		logic vsync;
		logic hsync;
		logic valid;
		logic mask;
		logic pclk;
		logic [PIX_W-1:0] data;
		logic normParkN;
		logic fastParkN;
	} pins_type;

	// Pixel written toward the mirror array frame store
	typedef struct packed {
		logic [POS_W-1:0] col;
		logic [POS_W-1:0] row;
		logic [PIX_W-1:0] value;
	} pixel_type;

	// Status word
	typedef struct packed {
		logic initDone;
		logic printReady;
		logic printActive;
		logic parked;
		logic seqRunning;
		logic vsyncLost;
		logic frameMasked;
	} status_type;

	typedef enum logic [1:0] {INIT_BOOT, INIT_AUTO, INIT_DONE} init_type;
	typedef enum logic [1:0] {PRINT_OFF, PRINT_SETUP, PRINT_READY, PRINT_EXPOSE} print_type;
	typedef enum logic [1:0] {PARK_RUN, PARK_BUSY, PARK_DONE} park_type;

endpackage

// *** core/print_host_if.sv ***
// Host-facing pixel, print handshake, park and start-up logic of the print controller
module print_host_if
	import print_if_pkg::*;
#(
	parameter int NormParkCyc = print_if_pkg::NORM_PARK_CYC,
	parameter int InitCyc = print_if_pkg::INIT_CYC,
	parameter int VsyncLossCyc = print_if_pkg::VSYNC_LOSS_CYC,
	parameter int PrintSetupCyc = print_if_pkg::PRINT_SETUP_CYC
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Parallel pixel input
	input wire logic vsyncIn,
	input wire logic hsyncIn,
	input wire logic pixelValidIn,
	input wire logic [print_if_pkg::PIX_W-1:0] pixelBus,
	input wire logic pixelClk,
	input wire logic frameMaskIn,
	// Park requests
	input wire logic normalParkReqN,
	input wire logic fastParkReqN,
	// Register port
	input wire logic [print_if_pkg::ADDR_W-1:0] regAddr,
	input wire logic [print_if_pkg::DATA_W-1:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [print_if_pkg::DATA_W-1:0] regRdata,
	// Print handshake
	output logic printReadyOut,
	output logic printActiveOut,
	// Start-up interrupt pin, tri-state style with enable, driven high or low
	output logic hostIrqOut,
	output logic hostIrqOeN,
	// Toward the array
	output print_if_pkg::pixel_type pixWrite,
	output logic pixWriteValid,
	output logic illumOn,
	output logic mirrorArrayParked
);
	import print_if_pkg::*;

	// Converts a cycle figure to a counter value
	function automatic logic [CNT_W-1:0] cyc(input int n);
		cyc = CNT_W'(n);
	endfunction

	// Saturating brightness offset used only outside print mode
	function automatic logic [PIX_W-1:0] satAdd(input logic [PIX_W-1:0] a,
		input logic [PIX_W-1:0] b);
		logic [PIX_W:0] s;
		s = {1'b0, a} + {1'b0, b};
		satAdd = s[PIX_W] ? {PIX_W{1'b1}} : s[PIX_W-1:0];
	endfunction

	// Active-edge test with selectable polarity
	function automatic logic activeEdge(input logic now, input logic prev, input logic fall);
		activeEdge = fall ? (prev & ~now) : (now & ~prev);
	endfunction

	// Chain starts at the idle pin levels, so reset cannot fake a park request edge
	localparam pins_type PINS_IDLE = '{normParkN: 1'b1, fastParkN: 1'b1, default: '0};

	pins_type pinsRaw; // Pins bundled for the chain
	pins_type sync1_r; // First stage, read only by the second
	pins_type sync2_r; // Second stage
	pins_type sync3_r; // Third stage
	pins_type stable_r; // Accepted value once stages two and three agree
	pins_type prev_r; // Previous accepted value for edge finding

	logic [CTRL_W-1:0] ctrl_r; // Mode bits
	logic [LAYER_W-1:0] layerFrames_r; // Frames per layer
	logic [PIX_W-1:0] bright_r; // Video offset
	logic [FRAMES_W-1:0] frames_r; // Frames shown
	init_type initState_r; // Start-up phase
	print_type printState_r; // Print flow
	park_type parkState_r; // Park flow
	logic [CNT_W-1:0] initCnt_r; // Start-up timer
	logic [CNT_W-1:0] parkCnt_r; // Park timer
	logic [CNT_W-1:0] setupCnt_r; // Print setup timer
	logic [CNT_W-1:0] vsLossCnt_r; // Time since last sync toggle
	logic [LAYER_W-1:0] exposed_r; // Frames exposed in this layer
	logic vsyncLost_r; // Sync stopped
	logic frameMasked_r; // Current frame blocked
	logic [POS_W-1:0] col_r; // Input column
	logic [POS_W-1:0] row_r; // Input row
	logic initDone; // Start-up complete
	logic seqRunning; // Sequencer may run
	logic vsEdge; // Frame start
	logic hsEdge; // Line start
	logic pclkRise; // Pixel clock edge
	logic layerCmd; // Accepted layer command
	status_type status; // Status word

	assign pinsRaw = '{vsync: vsyncIn, hsync: hsyncIn, valid: pixelValidIn,
		mask: frameMaskIn, pclk: pixelClk, data: pixelBus,
		normParkN: normalParkReqN, fastParkN: fastParkReqN};
	assign initDone = (initState_r == INIT_DONE);
	assign seqRunning = initDone & ~vsyncLost_r & (parkState_r == PARK_RUN);
	assign vsEdge = activeEdge(stable_r.vsync, prev_r.vsync, ctrl_r[CTRL_VS_FALL]);
	assign hsEdge = activeEdge(stable_r.hsync, prev_r.hsync, ctrl_r[CTRL_HS_FALL]);
	assign pclkRise = stable_r.pclk & ~prev_r.pclk;
	assign layerCmd = regWr & initDone & (regAddr == OFF_CMD) & regWdata[CMD_LAYER]
		& (printState_r == PRINT_READY);
	assign status = '{initDone: initDone, printReady: printReadyOut,
		printActive: printActiveOut, parked: mirrorArrayParked,
		seqRunning: seqRunning, vsyncLost: vsyncLost_r, frameMasked: frameMasked_r};

	// Three-stage chain; a change is taken only once the last two stages agree
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_r <= PINS_IDLE;
			sync2_r <= PINS_IDLE;
			sync3_r <= PINS_IDLE;
			stable_r <= PINS_IDLE;
			prev_r <= PINS_IDLE;
		end else if (ce) begin
			sync1_r <= pinsRaw;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			// Per bit, so a slow bit does not hold back the others
			for (int i = 0; i < $bits(pins_type); i++) begin
				if (sync2_r[i] == sync3_r[i]) begin
					stable_r[i] <= sync3_r[i];
				end
			end
			prev_r <= stable_r;
		end
	end

	// Register writes; ignored until start-up finishes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_r <= CTRL_RST;
			layerFrames_r <= LAYER_RST;
			bright_r <= BRIGHT_RST;
		end else if (ce && regWr && initDone) begin
			unique case (regAddr)
				OFF_CTRL: ctrl_r <= regWdata[CTRL_W-1:0];
				OFF_LAYER: layerFrames_r <= regWdata[LAYER_W-1:0];
				OFF_BRIGHT: bright_r <= regWdata[PIX_W-1:0];
				default: ; // Other offsets hold no writable state
			endcase
		end
	end

	// Read data stands in the cycle after the strobe only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			regRdata <= '0;
		end else if (ce) begin
			regRdata <= '0;
			if (regRd) begin
				unique case (regAddr)
					OFF_CTRL: regRdata <= DATA_W'(ctrl_r);
					OFF_LAYER: regRdata <= DATA_W'(layerFrames_r);
					OFF_BRIGHT: regRdata <= DATA_W'(bright_r);
					OFF_STATUS: regRdata <= DATA_W'(status);
					OFF_FRAMES: regRdata <= DATA_W'(frames_r);
					default: regRdata <= '0; // Unmapped and command offsets read zero
				endcase
			end
		end
	end

	// Start-up: undriven through boot, driven high during auto-init, low when done
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			initState_r <= INIT_BOOT;
			initCnt_r <= '0;
			hostIrqOut <= 1'b0;
			hostIrqOeN <= 1'b1;
		end else if (ce) begin
			unique case (initState_r)
				INIT_BOOT: begin
					if (initCnt_r == cyc(BOOT_CYC - 1)) begin
						initState_r <= INIT_AUTO;
						hostIrqOut <= 1'b1;
						hostIrqOeN <= 1'b0;
					end
					initCnt_r <= initCnt_r + 1'b1;
				end
				INIT_AUTO: begin
					// Whole start-up is bounded by the init figure
					if (initCnt_r == cyc(InitCyc - 1)) begin
						initState_r <= INIT_DONE;
						hostIrqOut <= 1'b0;
					end
					initCnt_r <= initCnt_r + 1'b1;
				end
				INIT_DONE: ;
			endcase
		end
	end

	// Park handling; fast request wins, both timed from the raw pin edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			parkState_r <= PARK_RUN;
			parkCnt_r <= '0;
			mirrorArrayParked <= 1'b0;
		end else if (ce) begin
			unique case (parkState_r)
				PARK_RUN: begin
					// Sync latency is taken off so the pin-to-done time meets the limit
					if (!stable_r.fastParkN) begin
						parkState_r <= PARK_BUSY;
						parkCnt_r <= cyc(FAST_PARK_CYC - 2 * SYNC_LAT);
					end else if (!stable_r.normParkN) begin
						parkState_r <= PARK_BUSY;
						parkCnt_r <= cyc(NormParkCyc - 2 * SYNC_LAT);
					end
				end
				PARK_BUSY: begin
					if (!stable_r.fastParkN && parkCnt_r > cyc(FAST_PARK_CYC - 2 * SYNC_LAT)) begin
						parkCnt_r <= cyc(FAST_PARK_CYC - 2 * SYNC_LAT);
					end else if (parkCnt_r == '0) begin
						parkState_r <= PARK_DONE;
						mirrorArrayParked <= 1'b1;
					end else begin
						parkCnt_r <= parkCnt_r - 1'b1;
					end
				end
				PARK_DONE: begin
					// Host keeps each level long, so release is a plain level test
					if (stable_r.fastParkN && stable_r.normParkN) begin
						parkState_r <= PARK_RUN;
						mirrorArrayParked <= 1'b0;
					end
				end
			endcase
		end
	end

	// Sync watchdog: any toggle of the vertical sync restarts it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			vsLossCnt_r <= '0;
			vsyncLost_r <= 1'b0;
		end else if (ce) begin
			if (stable_r.vsync != prev_r.vsync) begin
				vsLossCnt_r <= '0;
				vsyncLost_r <= 1'b0;
			end else if (initDone && vsLossCnt_r == cyc(VsyncLossCyc - 1)) begin
				vsyncLost_r <= 1'b1;
			end else if (initDone) begin
				vsLossCnt_r <= vsLossCnt_r + 1'b1;
			end
		end
	end

	// Mask is sampled at frame start, which lies in vertical blanking
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			frameMasked_r <= 1'b0;
			frames_r <= '0;
		end else if (ce && vsEdge && seqRunning) begin
			frameMasked_r <= stable_r.mask ^ ctrl_r[CTRL_MASK_LOW];
			if (!frameMasked_r) begin
				frames_r <= frames_r + 1'b1;
			end
		end
	end

	// Input position counters
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			col_r <= '0;
			row_r <= '0;
		end else if (ce) begin
			if (vsEdge) begin
				col_r <= '0;
				row_r <= '0;
			end else if (hsEdge) begin
				col_r <= '0;
				row_r <= (row_r == LAND_COLS - 1'b1) ? row_r : row_r + 1'b1;
			end else if (pclkRise && stable_r.valid && col_r != LAND_COLS - 1'b1) begin
				col_r <= col_r + 1'b1;
			end
		end
	end

	// Pixel capture; masked frames never reach the array, so the old image stays
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pixWrite <= '0;
			pixWriteValid <= 1'b0;
		end else if (ce) begin
			pixWriteValid <= 1'b0;
			if (pclkRise && stable_r.valid && seqRunning && !frameMasked_r) begin
				pixWriteValid <= 1'b1;
				if (ctrl_r[CTRL_ROTATE]) begin
					// Portrait column becomes row counted from the bottom
					pixWrite.col <= row_r;
					pixWrite.row <= PORT_COLS - 1'b1 - col_r;
				end else begin
					pixWrite.col <= col_r;
					pixWrite.row <= row_r;
				end
				// Print mode shows the pattern exactly, so no offset there
				pixWrite.value <= ctrl_r[CTRL_PRINT] ? stable_r.data
					: satAdd(stable_r.data, bright_r);
			end
		end
	end

	// Print flow: setup, ready, expose a layer, then dark
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			printState_r <= PRINT_OFF;
			setupCnt_r <= '0;
			exposed_r <= '0;
			printReadyOut <= 1'b0;
			printActiveOut <= 1'b0;
		end else if (ce) begin
			unique case (printState_r)
				PRINT_OFF: begin
					if (ctrl_r[CTRL_PRINT]) begin
						printState_r <= PRINT_SETUP;
						setupCnt_r <= '0;
					end
				end
				PRINT_SETUP: begin
					if (!ctrl_r[CTRL_PRINT]) begin
						printState_r <= PRINT_OFF;
					end else if (setupCnt_r == cyc(PrintSetupCyc - 1)) begin
						printState_r <= PRINT_READY;
						printReadyOut <= 1'b1;
					end else begin
						setupCnt_r <= setupCnt_r + 1'b1;
					end
				end
				PRINT_READY: begin
					if (!ctrl_r[CTRL_PRINT]) begin
						printState_r <= PRINT_OFF;
						printReadyOut <= 1'b0;
					end else if (layerCmd && seqRunning) begin
						printState_r <= PRINT_EXPOSE;
						exposed_r <= '0;
						printReadyOut <= 1'b0;
						printActiveOut <= 1'b1;
					end
				end
				PRINT_EXPOSE: begin
					// Losing sync or parking ends the layer early
					if (!seqRunning || exposed_r == layerFrames_r) begin
						printState_r <= PRINT_READY;
						printReadyOut <= 1'b1;
						printActiveOut <= 1'b0;
					end else if (vsEdge && !frameMasked_r) begin
						exposed_r <= exposed_r + 1'b1;
					end
				end
			endcase
		end
	end

	// Illumination follows the sequencer; in print mode only during a layer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			illumOn <= 1'b0;
		end else if (ce) begin
			illumOn <= seqRunning & (ctrl_r[CTRL_PRINT] ? (printState_r == PRINT_EXPOSE
				&& exposed_r != layerFrames_r) : 1'b1);
		end
	end

endmodule

// *** dv/print_host_if_chk.sv ***
// Port-level assertion checker for the print host interface
module print_host_if_chk
	import print_if_pkg::*;
#(
	parameter int NormParkCyc = 200
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Park pins
	input wire logic normalParkReqN,
	input wire logic fastParkReqN,
	// Register port
	input wire logic [print_if_pkg::ADDR_W-1:0] regAddr,
	input wire logic [print_if_pkg::DATA_W-1:0] regWdata,
	input wire logic regWr,
	// Outputs watched
	input wire logic printReadyOut,
	input wire logic printActiveOut,
	input wire logic hostIrqOut,
	input wire logic hostIrqOeN,
	input wire logic pixWriteValid,
	input wire logic illumOn,
	input wire logic mirrorArrayParked
);
	timeunit 1ns;
	timeprecision 1ns;
	// One clock domain, so clocking and reset are stated once
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// Request pin falls: the bounded wait for parking starts here
	sequence fastFall;
		$fell(fastParkReqN);
	endsequence
	sequence normFall;
		$fell(normalParkReqN);
	endsequence
	// A layer command accepted while ready
	sequence layerCmd;
		printReadyOut && regWr && regAddr == OFF_CMD && regWdata[0];
	endsequence

	a_irq_reset_float: assert property ($fell(rst) |-> hostIrqOeN)
		else $error("interrupt line driven at reset release");
	a_irq_boot_high: assert property ($fell(hostIrqOeN) |-> hostIrqOut)
		else $error("interrupt line driven low at end of boot");
	a_irq_low_driven: assert property ($fell(hostIrqOut) |-> !hostIrqOeN)
		else $error("init done edge not driven");
	a_fast_park: assert property (fastFall |-> ##[1:640] (mirrorArrayParked || fastParkReqN))
		else $error("fast park too slow");
	a_norm_park: assert property (normFall |-> ##[1:NormParkCyc] mirrorArrayParked)
		else $error("normal park too slow");
	a_layer_start: assert property (layerCmd |=> printActiveOut && !printReadyOut)
		else $error("layer command not taken");
	a_idle_dark: assert property (printReadyOut && $past(printReadyOut) && !printActiveOut
		|-> !illumOn)
		else $error("illumination on between layers");
	a_pix_after_init: assert property (pixWriteValid
		|-> !hostIrqOut && !hostIrqOeN && !mirrorArrayParked)
		else $error("pixel taken before init or while parked");
	a_pix_spaced: assert property (pixWriteValid |=> !pixWriteValid [*3])
		else $error("pixel captured twice per clock edge");
endmodule

// *** dv/host_pixel_src.sv ***
// Host model streaming frames onto the parallel pixel pins
module host_pixel_src (
	// Clock
	input wire logic clk,
	// Pixel pins
	output logic vsyncIn,
	output logic hsyncIn,
	output logic pixelValidIn,
	output logic [7:0] pixelBus,
	output logic pixelClk,
	output logic frameMaskIn
);
	timeunit 1ns;
	timeprecision 1ns;
	logic run = 1'b0; // Frames stream while set
	logic inv = 1'b0; // Sync idle level, active edge leaves it
	logic mask = 1'b0; // Held low when masking is unused
	logic havePix = 1'b0; // Next frame carries one line
	logic [7:0] px [4]; // Line contents
	int frameCount = 0; // Frames finished

	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask

	// One frame per pass; pixel clock stands still outside lines
	initial begin
		{vsyncIn, hsyncIn, pixelValidIn, pixelClk, frameMaskIn} = 5'h00;
		pixelBus = 8'h00;
		forever begin
			if (!run) begin
				@(posedge clk);
			end else begin
				frameMaskIn <= mask; // Only in blanking
				vsyncIn <= inv;
				hsyncIn <= inv;
				step(4);
				vsyncIn <= !inv; // Keeps toggling
				step(6);
				vsyncIn <= inv;
				step(6);
				hsyncIn <= !inv;
				step(6);
				hsyncIn <= inv;
				if (havePix) begin
					for (int i = 0; i < 4; i++) begin
						pixelBus <= px[i]; // 8-bit pixel
						pixelValidIn <= 1'b1;
						step(4);
						pixelClk <= 1'b1;
						step(4);
						pixelClk <= 1'b0;
					end
					pixelValidIn <= 1'b0;
					pixelBus <= ~px[3]; // Undriven bus must not echo the last pixel
					havePix = 1'b0;
				end
				step(8);
				frameCount++;
			end
		end
	end
endmodule

// *** dv/print_host_if_tb_top.sv ***
// Self-checking bench for the print host interface
module print_host_if_tb_top;
	import print_if_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	// Design ports
	logic clk, rst, ce, vsyncIn, hsyncIn, pixelValidIn, pixelClk, frameMaskIn;
	logic normalParkReqN, fastParkReqN, regWr, regRd, printReadyOut, printActiveOut;
	logic hostIrqOut, hostIrqOeN, pixWriteValid, illumOn, mirrorArrayParked;
	logic [7:0] pixelBus, regAddr;
	logic [31:0] regWdata, regRdata;
	pixel_type pixWrite;
	// Scoreboard state
	int mismatches = 0, comparisons = 0, cycles = 0, seed = 44, n;
	logic rot = 1'b0, rdPend = 1'b0;
	logic [31:0] rdQ [$], mkQ [$];
	logic [18:0] pxQ [$];

	print_host_if #(.NormParkCyc(200), .InitCyc(3000), .VsyncLossCyc(500),
		.PrintSetupCyc(50)) dut_u (.*);
	host_pixel_src src_u (.*);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic check(input string name, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Hang guard well above the planned run
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	// Takes the oldest note whenever an answer appears
	always @(posedge clk) begin
		rdPend <= regRd;
		if (rdPend) begin
			check("read data", regRdata & mkQ.pop_front(), rdQ.pop_front());
		end
		if (pixWriteValid === 1'b1) begin
			if (pxQ.size() == 0) begin
				check("stray pixel", 1, 0);
			end else begin
				check("pixel", {rot ? pixWrite.row : pixWrite.col, pixWrite.value},
					pxQ.pop_front());
			end
		end
	end

	// Strobes are lowered one edge before the next may rise
	task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rdReg(input logic [7:0] a, input logic [31:0] e, m);
		rdQ.push_back(e & m);
		mkQ.push_back(m);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		@(posedge clk);
	endtask

	task automatic frames(input int k);
		int f;
		f = src_u.frameCount;
		for (int i = 0; i < 200 * k && src_u.frameCount < f + k; i++) @(posedge clk);
	endtask

	// One random line; expected values saturate after the offset
	task automatic sendFrame(input logic [7:0] br, input logic take);
		logic [8:0] s;
		for (int i = 0; i < 4; i++) begin
			src_u.px[i] = 8'($random(seed));
			s = {1'b0, src_u.px[i]} + {1'b0, br};
			if (take) pxQ.push_back({rot ? 11'h2cf - 11'(i) : 11'(i), s[8] ? 8'hff : s[7:0]});
		end
		src_u.havePix = 1'b1;
		frames(2);
		check("pixels left", pxQ.size(), 0);
	endtask

	initial begin
		{rst, ce, normalParkReqN, fastParkReqN} = 4'hf;
		{regWr, regRd, regAddr, regWdata} = '0;
		repeat (3) @(posedge clk);
		check("irq at reset", hostIrqOeN, 1);
		rst <= 1'b0;
		@(posedge clk);
		wrReg(OFF_CTRL, 32'h2); // Dropped before init
		// The line value is low while undriven, so wait for driven and low together
		for (n = 0; n < 4000 && (hostIrqOut | hostIrqOeN) !== 1'b0; n++) @(posedge clk);
		check("init done", {hostIrqOut, hostIrqOeN, n < 3010}, 3'h1);
		rdReg(OFF_CTRL, 0, '1);
		rdReg(OFF_LAYER, 1, '1);
		rdReg(8'h20, 0, '1);
		rdReg(OFF_STATUS, 32'h40, 32'h40);
		src_u.run = 1'b1;
		// Both sync polarities, with and without rotation
		for (int k = 0; k < 4; k++) begin
			wrReg(OFF_CTRL, 32'({k[0], k[0], 1'b0, k[1], 1'b0}));
			src_u.inv = k[0];
			rot = k[1];
			frames(2);
			sendFrame(8'h00, 1'b1);
		end
		// Back to rising edges and no rotation before the mask runs
		src_u.inv = 1'b0;
		rot = 1'b0;
		// Mask blocks at either programmed level
		for (int p = 0; p < 2; p++) begin
			wrReg(OFF_CTRL, 32'(p << 2));
			src_u.mask = !p[0];
			frames(2);
			sendFrame(8'h00, 1'b0);
			src_u.mask = p[0];
			frames(2);
			sendFrame(8'h00, 1'b1);
		end
		src_u.mask = 1'b0;
		wrReg(OFF_CTRL, 0);
		frames(2);
		// Offset applies outside print mode only
		wrReg(OFF_BRIGHT, 32'hf0);
		sendFrame(8'hf0, 1'b1);
		wrReg(OFF_CTRL, 1);
		for (n = 0; n < 200 && printReadyOut !== 1'b1; n++) @(posedge clk);
		check("ready", printReadyOut, 1);
		sendFrame(8'h00, 1'b1);
		wrReg(OFF_LAYER, 3);
		wrReg(OFF_CMD, 1);
		for (n = 0; n < 300 && printActiveOut !== 1'b0; n++) @(posedge clk);
		check("layer span", {n >= 60, n < 130, printReadyOut}, 3'h7);
		wrReg(OFF_CTRL, 0);
		// Fast then normal park, normal levels held long
		fastParkReqN <= 1'b0;
		for (n = 0; n < 700 && mirrorArrayParked !== 1'b1; n++) @(posedge clk);
		// The flag set at edge 640 is seen here one edge later
		check("fast park", n < 642, 1);
		fastParkReqN <= 1'b1;
		repeat (50) @(posedge clk);
		normalParkReqN <= 1'b0;
		for (n = 0; n < 2000 && mirrorArrayParked !== 1'b1; n++) @(posedge clk);
		check("normal park", {n < 202, illumOn}, 2'h2);
		repeat (2000 - n) @(posedge clk);
		normalParkReqN <= 1'b1;
		repeat (2000) @(posedge clk);
		check("unparked", mirrorArrayParked, 0);
		// Sync stops: sequencer halts and goes dark
		src_u.run = 1'b0;
		repeat (600) @(posedge clk);
		check("dark", illumOn, 0);
		rdReg(OFF_STATUS, 32'h02, 32'h02);
		repeat (3) @(posedge clk);
		tally_and_finish();
	end
endmodule

bind print_host_if print_host_if_chk #(.NormParkCyc(NormParkCyc)) chk_u (.*);
